// [hdl/osdi_pkg.sv]
// osdi_pkg: constants and types of the serial display-ram access block
package osdi_pkg;

   // ==========================================
   // serial bus framing
   localparam logic [6:0] SLV_ADDR7 = 7'h5d;      // answers to 8'hba write, 8'hbb read
   localparam logic [3:0] BIT_LAST = 4'h8;        // bits per byte before the ack slot
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;

   // ==========================================
   // display ram geometry
   localparam int ROW_BITS = 4;
   localparam int COL_BITS = 5;
   localparam logic [3:0] CHAR_ROWS = 4'hf;       // rows 0..14 hold characters
   localparam logic [3:0] FRAME_ROW = 4'hf;       // 16th row: frame and amp control
   localparam logic [4:0] ROW_ATTR_COL = 5'h1e;   // 31st column: row attribute word
   localparam logic [4:0] FRAME_COLS = 5'h10;     // columns 0..15 used in the 16th row
   localparam int ROW_STRIDE = 31;                // 30 characters plus the attribute word
   localparam int RAM_WORDS = 481;                // 15 * 31 + 16
   localparam int RAM_AW = 9;
   localparam int FRAME_BASE = 465;               // first word of the 16th row

   // ==========================================
   // character word layout: low 9 bits pick one of 448 glyphs
   localparam int GLYPH_W = 9;
   localparam int ATTR_W = 7;

   // ==========================================
   // carriers
   typedef struct packed {
      logic [ROW_BITS-1:0] row;
      logic [COL_BITS-1:0] col;
   } osdi_addr_t;

   typedef struct packed {
      logic [ATTR_W-1:0] attr;
      logic [GLYPH_W-1:0] glyph;
   } osdi_word_t;

   typedef struct packed {
      logic valid;
      osdi_addr_t addr;
      osdi_word_t data;
   } osdi_wr_evt_t;

   // ==========================================
   // engine states and byte roles
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_TX, ST_TX, ST_ACK_RX, ST_WAIT} osdi_state_t;
   typedef enum logic [2:0] {RL_SLV, RL_ROW, RL_COL, RL_DHI, RL_DLO, RL_DONE} osdi_role_t;

endpackage : osdi_pkg

// [hdl/osdi_ram_access.sv]
// osdi_ram_access: serial-bus slave that reads and writes the display ram words
//
// What this block does
// (R1) write: address, row, column, two data, stop
// (R2) receiver acknowledges every byte, never start/stop; this block answers a third data byte with a nack
// (R3) row byte is sent before column byte
// (R4) answer to address bah write, bbh read
// (R5) only low four row bits select row
// (R6) only low five column bits select column
// (R7) every register is sixteen bits, two bytes
// (R8) read first sets address, no data, stop
// (R9) new start with read address returns two bytes
// (R10) row and column map directly onto words
// (R11) ram holds character, row, frame, amp groups
// (R12) character words cover 30 by 15 grid
// (R13) low nine bits glyph, upper seven attributes
// (R14) column 31 holds each row's attribute word
// (R15) row 16 holds frame control words
// (R16) amplifier control words also sit in row 16
// (R17) first data byte is the upper half
// (R18) unmapped writes ignored, unmapped reads give zero
`timescale 1ns/1ns
module osdi_ram_access
   import osdi_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // serial bus pins (open drain data)
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // display-side read port
   input wire osdi_addr_t disp_addr,
   output osdi_word_t disp_word,
   // one-cycle notice of each committed write
   output osdi_wr_evt_t wr_evt
);

   // ==========================================
   // pin synchronisers
   logic scl_m_r, scl_s_r, scl_d_r;   // meta stage, stable stage, previous stable
   logic sda_m_r, sda_s_r, sda_d_r;
   logic scl_rise, scl_fall, start_det, stop_det;

   // bus idles high, so reset the chain to ones
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_m_r <= scl_in;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   // edges and conditions, only from the stable stages
   always_comb begin
      scl_rise = scl_s_r & ~scl_d_r;
      scl_fall = ~scl_s_r & scl_d_r;
      start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;   // data falls while clock high
      stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;    // data rises while clock high
   end

   // ==========================================
   // address decode
   // row/column pair to storage word; the grid is packed densely so no word is wasted
   function automatic logic addr_ok(osdi_addr_t a);
      addr_ok = ((a.row < CHAR_ROWS) && (a.col <= ROW_ATTR_COL))    // R12 R14
         || ((a.row == FRAME_ROW) && (a.col < FRAME_COLS));         // R15 R16
   endfunction : addr_ok

   function automatic logic [RAM_AW-1:0] ram_index(osdi_addr_t a);
      logic [RAM_AW-1:0] base;
      base = RAM_AW'(a.row) * RAM_AW'(ROW_STRIDE);
      if (a.row == FRAME_ROW) begin
         ram_index = RAM_AW'(FRAME_BASE) + RAM_AW'(a.col);           // R16
      end else begin
         ram_index = base + RAM_AW'(a.col);                          // R10
      end
   endfunction : ram_index

   // ==========================================
   // storage and engine state
   osdi_word_t mem_r [RAM_WORDS];     // four groups in one flip-flop array (R11)
   osdi_word_t mem_nxt [RAM_WORDS];
   osdi_state_t state_r, state_nxt;
   osdi_role_t role_r, role_nxt;      // meaning of the byte in flight
   logic [3:0] bit_r, bit_nxt;        // bits moved in the current byte
   logic [BYTE_W-1:0] sh_r, sh_nxt;   // receive shifter
   logic [BYTE_W-1:0] tx_r, tx_nxt;   // transmit shifter
   logic [BYTE_W-1:0] hi_r, hi_nxt;   // held upper data byte
   logic rw_r, rw_nxt;                // direction of the current transaction
   logic acked_r, acked_nxt;          // master answered our byte with ack
   logic oe_r, oe_nxt;                // pulling data low
   osdi_addr_t ptr_r, ptr_nxt;        // word pointer kept across transactions
   osdi_wr_evt_t wr_r, wr_nxt;
   osdi_word_t disp_r, disp_nxt;
   logic [WORD_W-1:0] rd_word;

   // unmapped locations read as zero
   always_comb begin
      rd_word = addr_ok(ptr_r) ? mem_r[ram_index(ptr_r)] : '0;      // R18
   end

   // ==========================================
   // byte engine next state
   always_comb begin
      state_nxt = state_r;
      role_nxt = role_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      hi_nxt = hi_r;
      rw_nxt = rw_r;
      acked_nxt = acked_r;
      oe_nxt = oe_r;
      ptr_nxt = ptr_r;
      wr_nxt = '0;
      if (stop_det) begin
         // stop ends any transaction; pointer survives for a later read (R8)
         state_nxt = ST_IDLE;
         oe_nxt = 1'b0;
      end else if (start_det) begin
         // start or repeated start always expects the slave address (R1 R9)
         state_nxt = ST_RX;
         role_nxt = RL_SLV;
         bit_nxt = '0;
         oe_nxt = 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE, ST_WAIT: begin
               // nothing until the next start
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[BYTE_W-2:0], sda_s_r};
                  bit_nxt = bit_r + 4'h1;
               end else if (scl_fall && (bit_r == BIT_LAST)) begin
                  // byte complete: pull the ack on this falling edge (R2)
                  state_nxt = ST_ACK_TX;
                  oe_nxt = 1'b1;
                  bit_nxt = '0;
                  unique case (role_r)
                     RL_SLV: begin
                        if (sh_r[BYTE_W-1:1] == SLV_ADDR7) begin   // R4
                           rw_nxt = sh_r[0];
                        end else begin
                           state_nxt = ST_WAIT;                    // not ours, stay off
                           oe_nxt = 1'b0;
                        end
                     end
                     RL_ROW: ptr_nxt.row = sh_r[ROW_BITS-1:0];      // R5
                     RL_COL: ptr_nxt.col = sh_r[COL_BITS-1:0];      // R6
                     RL_DHI: hi_nxt = sh_r;                         // R17
                     RL_DLO: begin
                        // both halves in hand: commit only to mapped words (R7 R18)
                        wr_nxt.valid = addr_ok(ptr_r);
                        wr_nxt.addr = ptr_r;
                        wr_nxt.data = {hi_r, sh_r};                 // R17
                     end
                     RL_DONE: begin
                        // a third data byte is refused with a nack
                        state_nxt = ST_WAIT;
                        oe_nxt = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK_TX: begin
               if (scl_fall) begin
                  oe_nxt = 1'b0;
                  bit_nxt = '0;
                  if ((role_r == RL_SLV) && rw_r) begin
                     // read: upper byte goes out first, msb on this edge (R9)
                     state_nxt = ST_TX;
                     role_nxt = RL_DHI;
                     tx_nxt = rd_word[WORD_W-1:BYTE_W];
                     oe_nxt = ~rd_word[WORD_W-1];
                  end else begin
                     state_nxt = ST_RX;
                     unique case (role_r)
                        RL_SLV: role_nxt = RL_ROW;                  // R3
                        RL_ROW: role_nxt = RL_COL;                  // R3
                        RL_COL: role_nxt = RL_DHI;
                        RL_DHI: role_nxt = RL_DLO;
                        RL_DLO, RL_DONE: role_nxt = RL_DONE;
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_nxt = bit_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_r == BIT_LAST) begin
                     state_nxt = ST_ACK_RX;                         // release for master ack
                     oe_nxt = 1'b0;
                  end else begin
                     tx_nxt = {tx_r[BYTE_W-2:0], 1'b0};
                     oe_nxt = ~tx_r[BYTE_W-2];
                  end
               end
            end
            ST_ACK_RX: begin
               if (scl_rise) begin
                  acked_nxt = ~sda_s_r;                             // R2
               end else if (scl_fall) begin
                  bit_nxt = '0;
                  if (acked_r && (role_r == RL_DHI)) begin
                     state_nxt = ST_TX;                             // R9
                     role_nxt = RL_DLO;
                     tx_nxt = rd_word[BYTE_W-1:0];
                     oe_nxt = ~rd_word[BYTE_W-1];
                  end else begin
                     state_nxt = ST_WAIT;                           // after two bytes or nack
                  end
               end
            end
         endcase
      end
   end

   // ==========================================
   // ram write and display-side read
   always_comb begin
      mem_nxt = mem_r;
      if (wr_nxt.valid) begin
         mem_nxt[ram_index(wr_nxt.addr)] = wr_nxt.data;              // R10
      end
      disp_nxt = addr_ok(disp_addr) ? mem_r[ram_index(disp_addr)] : '0;  // R18
   end

   // ==========================================
   // registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         role_r <= RL_SLV;
         bit_r <= '0;
         sh_r <= '0;
         tx_r <= '0;
         hi_r <= '0;
         rw_r <= 1'b0;
         acked_r <= 1'b0;
         oe_r <= 1'b0;
         ptr_r <= '0;
         wr_r <= '0;
         disp_r <= '0;
         for (int i = 0; i < RAM_WORDS; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         state_r <= state_nxt;
         role_r <= role_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         hi_r <= hi_nxt;
         rw_r <= rw_nxt;
         acked_r <= acked_nxt;
         oe_r <= oe_nxt;
         ptr_r <= ptr_nxt;
         wr_r <= wr_nxt;
         disp_r <= disp_nxt;
         mem_r <= mem_nxt;
      end
   end

   // open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe = oe_r;
   assign wr_evt = wr_r;
   assign disp_word = disp_r;   // R13

   // ==========================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_start_expects_addr: assert property ( // R1
      start_det && !stop_det |=> (state_r == ST_RX) && (role_r == RL_SLV) && (bit_r == 4'h0))
      else $error("start did not arm address reception");
   a_stop_goes_idle: assert property ( // R1
      stop_det |=> (state_r == ST_IDLE) && !sda_oe)
      else $error("stop did not release the bus");
   a_ack_slot_low: assert property ( // R2
      (state_r == ST_ACK_TX) |-> sda_oe)
      else $error("ack slot not driven low");
   a_foreign_addr: assert property ( // R4
      (state_r == ST_RX) && (role_r == RL_SLV) && scl_fall && (bit_r == BIT_LAST)
      && !start_det && !stop_det && (sh_r[7:1] != SLV_ADDR7)
      |=> (state_r == ST_WAIT) && !sda_oe)
      else $error("foreign address was acknowledged");
   a_row_then_col: assert property ( // R3
      (role_r == RL_ROW) && (state_r == ST_ACK_TX) && scl_fall && !start_det && !stop_det
      |=> (role_r == RL_COL))
      else $error("column byte did not follow row byte");
   a_row_mask: assert property ( // R5
      (role_r == RL_ROW) && (state_r == ST_RX) && scl_fall && (bit_r == BIT_LAST)
      && !start_det && !stop_det |=> ptr_r.row == $past(sh_r[3:0]))
      else $error("row pointer not from low four bits");
   a_col_mask: assert property ( // R6
      (role_r == RL_COL) && (state_r == ST_RX) && scl_fall && (bit_r == BIT_LAST)
      && !start_det && !stop_det |=> ptr_r.col == $past(sh_r[4:0]))
      else $error("column pointer not from low five bits");
   a_upper_first: assert property ( // R17
      wr_evt.valid |-> (wr_evt.data[15:8] == hi_r) && (wr_evt.data[7:0] == sh_r))
      else $error("data byte order wrong");

   a_write_lands: assert property ( // R10
      wr_evt.valid |-> mem_r[ram_index(wr_evt.addr)] == wr_evt.data)
      else $error("write did not reach storage");

   a_unmapped_quiet: assert property ( // R18
      wr_evt.valid |-> addr_ok(wr_evt.addr))
      else $error("write to unmapped location");

   a_read_msb_out: assert property ( // R9
      (state_r == ST_ACK_TX) && (role_r == RL_SLV) && rw_r && scl_fall
      && !start_det && !stop_det |=> (state_r == ST_TX) && (sda_oe == !$past(rd_word[15])))
      else $error("read upper byte msb not presented");

   c_write_commit: cover property (wr_evt.valid);
   c_read_second_byte: cover property ((state_r == ST_TX) && (role_r == RL_DLO));
   c_address_only: cover property ((role_r == RL_DHI) && (state_r == ST_RX) ##1 stop_det);
   c_frame_row_write: cover property (wr_evt.valid && (wr_evt.addr.row == FRAME_ROW));

endmodule : osdi_ram_access

// [verification/osdi_mst_model.sv]
// osdi_mst_model: behavioural serial bus master standing in for the controller
`timescale 1ns/1ns
module osdi_mst_model (
   // clock that paces the bit timing
   input wire logic clock,
   // wired data level as seen on the bus
   input wire logic sda,
   // driven bus lines (data is open drain, pull-up when released)
   output logic scl,
   output logic sda_low
);
   // ==========================================
   // idle bus: both lines high, clock stands still
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ==========================================
   // timing helpers
   // one quarter of the 320 ns serial period, launched just after an edge
   task automatic qtr();
      repeat (2) @(posedge clock);
      #1;
   endtask : qtr

   // one bit slot: data set in the low phase, sampled late in the high phase
   task automatic bit_c(input logic b, output logic s);
      sda_low = !b;
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      s = sda;
      scl = 1'b0;
      qtr();
   endtask : bit_c

   // ==========================================
   // framing
   // start, also usable as repeated start from a low clock
   task automatic start_c();
      sda_low = 1'b0;
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      sda_low = 1'b1;
      qtr();
      qtr();
      scl = 1'b0;
      qtr();
   endtask : start_c

   // stop: data rises while the clock is high, then the clock stands still
   task automatic stop_c();
      sda_low = 1'b1;
      qtr();
      scl = 1'b1;
      qtr();
      qtr();
      sda_low = 1'b0;
      qtr();
      qtr();
   endtask : stop_c

   // ==========================================
   // byte transfers, msb first, then the acknowledge slot
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_c(b[i], ack);
      end
      bit_c(1'b1, ack);
   endtask : put_byte

   // read a byte; mack high means the master acknowledges it
   task automatic get_byte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, s);
         b[i] = s;
      end
      bit_c(!mack, s);
   endtask : get_byte
endmodule : osdi_mst_model

// [verification/tb_top.sv]
// tb_top: self-checking bench for the serial display-ram access block
`timescale 1ns/1ns
module tb_top
   import osdi_pkg::*;
;
   // ==========================================
   // signals
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic scl;
   logic sda_low;
   logic sda_out;
   logic sda_oe;
   wire logic sda;
   osdi_addr_t disp_addr = '0;
   osdi_word_t disp_word;
   osdi_wr_evt_t wr_evt;
   osdi_wr_evt_t last_evt = '0; // last write notice seen
   int n_evt = 0;
   int miscompares = 0;
   int n_checks = 0;

   // 25 MHz clock
   always #20 clock = ~clock;

   // open-drain data: low if either party pulls, pull-up otherwise
   assign sda = !(sda_low || (sda_oe && !sda_out));

   // ==========================================
   // design and bus master
   osdi_ram_access dut (
      .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .disp_addr(disp_addr),
      .disp_word(disp_word), .wr_evt(wr_evt)
   );
   osdi_mst_model m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

   // write notices are one-cycle pulses, so count them as they pass
   always @(posedge clock) begin
      if (wr_evt.valid === 1'b1) begin
         n_evt <= n_evt + 1;
         last_evt <= wr_evt;
      end
   end

   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // one byte with its expected acknowledge bit (0 = ack)
   task automatic send(input logic [7:0] b, input logic ackx, input string what);
      logic a;
      m.put_byte(b, a);
      chk(what, {15'h0000, ackx}, {15'h0000, a});
   endtask : send

   task automatic wr_word(input logic [7:0] r, input logic [7:0] c, input logic [15:0] d);
      m.start_c();
      send(8'hba, 1'b0, "write address ack");
      send(r, 1'b0, "row ack");
      send(c, 1'b0, "column ack");
      send(d[15:8], 1'b0, "high byte ack");
      send(d[7:0], 1'b0, "low byte ack");
      m.stop_c();
   endtask : wr_word

   // address-only write, then a read of both bytes
   task automatic rd_word(input logic [7:0] r, input logic [7:0] c, output logic [15:0] d);
      m.start_c();
      send(8'hba, 1'b0, "write address ack");
      send(r, 1'b0, "row ack");
      send(c, 1'b0, "column ack");
      m.stop_c();
      m.start_c();
      send(8'hbb, 1'b0, "read address ack");
      m.get_byte(1'b1, d[15:8]);
      m.get_byte(1'b0, d[7:0]);
      m.stop_c();
   endtask : rd_word

   // display port: address at edge n, word after edge n+1
   task automatic dchk(input osdi_addr_t a, input logic [15:0] exp);
      @(posedge clock) #1;
      disp_addr = a;
      repeat (2) @(posedge clock);
      #1;
      chk("display word", exp, disp_word);
   endtask : dchk

   // ==========================================
   // scenarios
   // write then read back, with junk in the ignored address bits
   task automatic t_basic();
      logic [15:0] w;
      int n0 = n_evt;
      wr_word(8'hf3, 8'he7, 16'ha5c3);
      chk("write notices", 16'(n0 + 1), 16'(n_evt));
      chk("notice address", 16'h0067, {7'h00, last_evt.addr});
      chk("notice data", 16'ha5c3, last_evt.data);
      dchk({4'h3, 5'h07}, 16'ha5c3);
      chk("glyph field", 16'h01c3, {7'h00, disp_word.glyph});
      rd_word(8'h03, 8'h07, w);
      chk("serial read", 16'ha5c3, w);
      $display("test basic done");
   endtask : t_basic

   // each register group, its edges, and places outside the map
   task automatic t_map();
      logic [7:0] rb [6] = '{8'h0e, 8'h0e, 8'h0f, 8'h0f, 8'h0f, 8'h05};
      logic [7:0] cb [6] = '{8'h1e, 8'h1d, 8'h02, 8'h0f, 8'h10, 8'h1f};
      logic [5:0] keep = 6'h0f;
      logic [15:0] d;
      logic [15:0] w;
      int n0;
      for (int i = 0; i < 6; i++) begin
         d = 16'(16'h1111 * (i + 1));
         n0 = n_evt;
         wr_word(rb[i], cb[i], d);
         chk("write notices", 16'(n0 + keep[i]), 16'(n_evt));
         dchk({rb[i][3:0], cb[i][4:0]}, keep[i] ? d : 16'h0000);
         rd_word(rb[i], cb[i], w);
         chk("serial read", keep[i] ? d : 16'h0000, w);
      end
      $display("test map done");
   endtask : t_map

   // foreign addresses, a third data byte and a lone data byte
   task automatic t_refuse();
      logic [7:0] bad [2] = '{8'hb8, 8'h3a};
      int n0;
      foreach (bad[i]) begin
         m.start_c();
         send(bad[i], 1'b1, "foreign address nack");
         m.stop_c();
      end
      m.start_c();
      send(8'hba, 1'b0, "write address ack");
      send(8'h01, 1'b0, "row ack");
      send(8'h01, 1'b0, "column ack");
      send(8'h12, 1'b0, "high byte ack");
      send(8'h34, 1'b0, "low byte ack");
      send(8'h56, 1'b1, "third byte nack");
      m.stop_c();
      dchk({4'h1, 5'h01}, 16'h1234);
      n0 = n_evt;
      m.start_c();
      send(8'hba, 1'b0, "write address ack");
      send(8'h02, 1'b0, "row ack");
      send(8'h02, 1'b0, "column ack");
      send(8'h77, 1'b0, "high byte ack");
      m.stop_c();
      chk("write notices", 16'(n0), 16'(n_evt));
      dchk({4'h2, 5'h02}, 16'h0000);
      $display("test refuse done");
   endtask : t_refuse

   // ==========================================
   // verdict
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // main sequence: reset for 12 cycles, settle, then the scenarios
   initial begin
      repeat (12) @(posedge clock);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clock);
      t_basic();
      t_map();
      t_refuse();
      summarize();
   end

   // watchdog: the scenarios need well under 1 ms, so a hang is caught early
   initial begin
      #1_000_000;
      miscompares++;
      summarize();
   end
endmodule : tb_top
